// ---- rtl/xfer_pkg.sv ----
package xfer_pkg;
  // register map of the control slave, byte addresses
  localparam logic [7:0] OFS_INSTR  = 8'h00;
  localparam logic [7:0] OFS_EXT    = 8'h04;
  localparam logic [7:0] OFS_CTRL   = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_FLAGS  = 8'h10;
  localparam logic [2:0] GPR_REGION = 3'h1;
  localparam int         CTRL_GO    = 0;
  localparam int         ST_BUSY    = 0;
  localparam int         ST_ILLEGAL = 1;
  localparam int         ST_TAKEN   = 2;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [15:0] INSTR_RESET = 16'h0000;
  // opcode word fields
  localparam int KIND_HI  = 15;
  localparam int KIND_LO  = 12;
  localparam int SIZE_BIT = 11;
  localparam int DIR_BIT  = 10;
  // operation kinds
  localparam logic [3:0] K_RR        = 4'h0;
  localparam logic [3:0] K_IND       = 4'h1;
  localparam logic [3:0] K_DISP      = 4'h2;
  localparam logic [3:0] K_AUTO      = 4'h3;
  localparam logic [3:0] K_ABS16     = 4'h4;
  localparam logic [3:0] K_IMM16     = 4'h5;
  localparam logic [3:0] K_IMM8      = 4'h6;
  localparam logic [3:0] K_ABS8_LD   = 4'h7;
  localparam logic [3:0] K_ABS8_ST   = 4'h8;
  localparam logic [3:0] K_SYNC      = 4'h9;
  localparam logic [3:0] K_STACK     = 4'ha;
  localparam logic [3:0] K_CCR_STACK = 4'hb;
  localparam logic [3:0] K_BRANCH    = 4'hc;
  // condition_flags_register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  // condition codes of the branch
  localparam logic [3:0] CC_T  = 4'h0, CC_F  = 4'h1, CC_HI = 4'h2, CC_LS = 4'h3;
  localparam logic [3:0] CC_CC = 4'h4, CC_CS = 4'h5, CC_NE = 4'h6, CC_EQ = 4'h7;
  localparam logic [3:0] CC_VC = 4'h8, CC_VS = 4'h9, CC_PL = 4'ha, CC_MI = 4'hb;
  localparam logic [3:0] CC_GE = 4'hc, CC_LT = 4'hd, CC_GT = 4'he, CC_LE = 4'hf;
  localparam logic [2:0] SP_INDEX   = 3'h7;
  localparam logic [7:0] SHORT_PAGE = 8'hff;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  // slow peripheral clock period in system clocks
  localparam int E_DIV_DEFAULT = 8;
endpackage : xfer_pkg

// ---- rtl/gpr_file.sv ----
`timescale 1ns/1ns
module gpr_file #(
  parameter int W  = 16,
  parameter int AW = 3
) (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          arst_n,
  // read ports, data one clock after the address
  input  wire logic [AW-1:0] ra_addr,
  input  wire logic [AW-1:0] rb_addr,
  output logic      [W-1:0]  ra_data,
  output logic      [W-1:0]  rb_data,
  // write port with half-word enables
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic          wr_hi,
  input  wire logic          wr_lo,
  input  wire logic [W-1:0]  wr_data
);
  localparam int N = 2 ** AW;
  localparam int H = W / 2;

  if (W % 2 != 0 || W < 2) begin : g_bad_width
    $error("gpr_file width must be even");
  end

  logic [W-1:0] regs [N];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < N; i++) begin
        regs[i] <= '0;
      end
    end else begin
      if (wr_hi) begin
        regs[wr_addr][W-1:H] <= wr_data[W-1:H];
      end
      if (wr_lo) begin
        regs[wr_addr][H-1:0] <= wr_data[H-1:0];
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ra_data <= '0;
      rb_data <= '0;
    end else begin
      ra_data <= regs[ra_addr];
      rb_data <= regs[rb_addr];
    end
  end
endmodule : gpr_file

// ---- rtl/cpu_data_transfer_decode.sv ----
// Contract
// [RULE1] push lowers the stack pointer by two and stores one word register at the new address.
// [RULE2] pop loads one word register from the stack pointer address and then raises the pointer by two.
// [RULE3] move copies register to register, register to memory, memory to register or immediate to register.
// [RULE4] byte and word moves offer direct, indirect, displacement, long absolute, immediate, predec and postinc.
// [RULE5] the short absolute form exists only for byte operands.
// [RULE6] software uses only word size for predecrement or postincrement through the stack pointer register.
// [RULE7] the slow synchronized store writes one byte timed to the slow peripheral clock.
// [RULE8] the slow synchronized load reads one byte timed to the slow peripheral clock.
// [RULE9] the conditional branch carries a condition field that picks the flag test.
// [RULE10] the flags register holds negative, zero, overflow and carry that moves update and branches test.
// [RULE11] displacement and long absolute forms take their value from a second instruction word.
// [RULE12] word accesses force address bit zero low without any error.
// [RULE13] pushing the flags writes two copies in one word and popping ignores the lower byte.
//
// Design decisions made here: the Wishbone slave port and the address map.
`timescale 1ns/1ns
module cpu_data_transfer_decode import xfer_pkg::*; #(
  parameter int E_DIV = E_DIV_DEFAULT
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // memory and peripheral bus
  output logic             mem_req,
  output logic             mem_we,
  output logic             mem_word,
  output logic             mem_sync,
  output logic      [15:0] mem_addr,
  output logic      [15:0] mem_wdata,
  input  wire logic [15:0] mem_rdata,
  input  wire logic        mem_ack,
  output logic             e_clock
);
  if (E_DIV < 2 || E_DIV > 256) begin : g_bad_div
    $error("E_DIV must be 2 to 256");
  end
  localparam logic [7:0] E_LAST = 8'(E_DIV - 1);
  localparam logic [7:0] E_HALF = 8'(E_DIV / 2);
  typedef enum logic [6:0] {
    S_IDLE  = 7'b0000001,
    S_READ  = 7'b0000010,
    S_ADDR  = 7'b0000100,
    S_EWAIT = 7'b0001000,
    S_MEM   = 7'b0010000,
    S_WB    = 7'b0100000,
    S_PTR   = 7'b1000000
  } state_t;
  state_t      state;
  logic [15:0] instr, ext, result, ptr, ra_data, rb_data;
  logic [7:0]  flags, e_cnt;
  logic        illegal, taken, pend;
  // bus decode
  wire         bus_wr    = pend & wb_we_i;
  wire         idle      = (state == S_IDLE);
  wire         hit_gpr   = (wb_adr_i[7:5] == GPR_REGION) & (wb_adr_i[1:0] == 2'h0);
  wire  [2:0]  gpr_idx   = wb_adr_i[4:2];
  wire         wr_instr  = bus_wr & idle & (wb_adr_i == OFS_INSTR);
  wire         wr_ext    = bus_wr & idle & (wb_adr_i == OFS_EXT);
  wire         wr_flags  = bus_wr & idle & (wb_adr_i == OFS_FLAGS) & wb_sel_i[0];
  wire         go        = bus_wr & idle & (wb_adr_i == OFS_CTRL) & wb_sel_i[0] & wb_dat_i[CTRL_GO];
  wire         bus_gpr_w = bus_wr & idle & hit_gpr;
  wire  [15:0] ins_next  = {wb_sel_i[1] ? wb_dat_i[15:8] : instr[15:8], wb_sel_i[0] ? wb_dat_i[7:0] : instr[7:0]};
  wire  [15:0] ext_next  = {wb_sel_i[1] ? wb_dat_i[15:8] : ext[15:8], wb_sel_i[0] ? wb_dat_i[7:0] : ext[7:0]};
  wire  [31:0] rd_word   = (wb_adr_i == OFS_INSTR)  ? {16'h0000, instr} :
                           (wb_adr_i == OFS_EXT)    ? {16'h0000, ext} :
                           (wb_adr_i == OFS_STATUS) ? {29'h0, taken, illegal, ~idle} :
                           (wb_adr_i == OFS_FLAGS)  ? {24'h0, flags} :
                           hit_gpr                  ? {16'h0000, ra_data} : 32'h0;

  // instruction decode
  wire  [3:0]  kind      = instr[KIND_HI:KIND_LO];
  wire         is_store  = instr[DIR_BIT];
  wire         short_fmt = (kind == K_IMM8) | (kind == K_ABS8_LD) | (kind == K_ABS8_ST);
  wire  [3:0]  rn4       = short_fmt ? instr[11:8] : instr[3:0];
  wire         stack_k   = (kind == K_STACK) | (kind == K_CCR_STACK);
  wire         byte_only = short_fmt | (kind == K_SYNC);                            // [RULE5]
  wire         word_op   = stack_k | (kind == K_IMM16) | (~byte_only & instr[SIZE_BIT]);
  wire  [2:0]  base_idx  = stack_k ? SP_INDEX : instr[6:4];
  wire         ptr_k     = stack_k | (kind == K_AUTO);
  wire         reg_only  = (kind == K_RR) | (kind == K_IMM8) | (kind == K_IMM16);
  wire         load_op   = (kind == K_ABS8_LD) | (~is_store & (kind != K_ABS8_ST));
  wire         legal     = (kind <= K_BRANCH);
  wire  [15:0] step      = word_op ? STEP_WORD : STEP_BYTE;
  wire  [7:0]  ra_byte   = instr[7] ? ra_data[7:0] : ra_data[15:8];
  wire  [7:0]  rb_byte   = rn4[3] ? rb_data[7:0] : rb_data[15:8];
  // effective address for every mode
  wire  [15:0] ea_raw    = (kind == K_DISP)                         ? 16'(ra_data + ext) : // [RULE4] [RULE11]
                           (kind == K_ABS16) | (kind == K_SYNC)     ? ext :                // [RULE11]
                           (kind == K_ABS8_LD) | (kind == K_ABS8_ST) ? {SHORT_PAGE, instr[7:0]} :
                           (ptr_k & is_store)                       ? 16'(ra_data - step) : // [RULE1]
                           ra_data;                                                        // [RULE2]
  wire  [15:0] ea        = word_op ? {ea_raw[15:1], 1'b0} : ea_raw;                        // [RULE12]
  wire  [15:0] ptr_next  = is_store ? 16'(ra_data - step) : 16'(ra_data + step);           // [RULE1] [RULE2]
  wire  [15:0] st_data   = (kind == K_CCR_STACK) ? {flags, flags} :                        // [RULE13]
                           word_op ? rb_data : {rb_byte, rb_byte};
  wire  [15:0] mv_data   = (kind == K_IMM16) ? ext :                                       // [RULE3]
                           (kind == K_IMM8)  ? {8'h00, instr[7:0]} :
                           word_op ? ra_data : {8'h00, ra_byte};
  wire  [15:0] ld_data   = word_op ? mem_rdata : {8'h00, mem_rdata[7:0]};
  wire         mem_done  = mem_sync ? (e_cnt == E_LAST) : mem_ack;                         // [RULE7] [RULE8]
  wire         ccr_pop   = (kind == K_CCR_STACK) & ~is_store;
  // register file access, the bus only touches it while idle
  wire  [2:0]  ra_addr   = idle ? gpr_idx : base_idx;
  wire         wb_byte   = ~word_op & (state == S_WB);
  wire         wr_hi     = bus_gpr_w ? wb_sel_i[1] : (state == S_PTR) | (state == S_WB & (word_op | ~rn4[3]));
  wire         wr_lo     = bus_gpr_w ? wb_sel_i[0] : (state == S_PTR) | (state == S_WB & (word_op | rn4[3]));
  wire  [2:0]  wr_addr   = bus_gpr_w ? gpr_idx : (state == S_PTR) ? base_idx : rn4[2:0];
  wire  [15:0] wr_data   = bus_gpr_w ? wb_dat_i[15:0] : (state == S_PTR) ? ptr :
                           wb_byte ? {result[7:0], result[7:0]} : result;
  // flag update for moves
  wire         fl_move   = (state == S_WB) | (state == S_MEM & mem_done & mem_we & ~stack_k) |
                           (state == S_MEM & mem_done & mem_we & kind == K_STACK);
  wire  [15:0] fl_src    = (state == S_WB) ? result : mem_wdata;
  wire         fl_neg    = word_op ? fl_src[15] : fl_src[7];
  wire         fl_zero   = word_op ? (fl_src == 16'h0000) : (fl_src[7:0] == 8'h00);
  function automatic logic cc_true(input logic [3:0] cc, input logic [7:0] f);
    logic n, z, v, c;
    {n, z, v, c} = {f[FLAG_N], f[FLAG_Z], f[FLAG_V], f[FLAG_C]};
    unique case (cc)
      CC_T:  cc_true = 1'b1;
      CC_F:  cc_true = 1'b0;
      CC_HI: cc_true = ~(c | z);
      CC_LS: cc_true = c | z;
      CC_CC: cc_true = ~c;
      CC_CS: cc_true = c;
      CC_NE: cc_true = ~z;
      CC_EQ: cc_true = z;
      CC_VC: cc_true = ~v;
      CC_VS: cc_true = v;
      CC_PL: cc_true = ~n;
      CC_MI: cc_true = n;
      CC_GE: cc_true = ~(n ^ v);
      CC_LT: cc_true = n ^ v;
      CC_GT: cc_true = ~(z | (n ^ v));
      CC_LE: cc_true = z | (n ^ v);
    endcase
  endfunction : cc_true

  gpr_file #(.W(16), .AW(3)) u_gpr (
    .clock   (clock),
    .arst_n  (arst_n),
    .ra_addr (ra_addr),
    .rb_addr (rn4[2:0]),
    .ra_data (ra_data),
    .rb_data (rb_data),
    .wr_addr (wr_addr),
    .wr_hi   (wr_hi),
    .wr_lo   (wr_lo),
    .wr_data (wr_data)
  );

  // slave answers on the second edge so register-file reads can settle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pend     <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      pend     <= wb_cyc_i & wb_stb_i & ~pend & ~wb_ack_o;
      wb_ack_o <= pend;
      if (pend) begin
        wb_dat_o <= rd_word;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      instr <= INSTR_RESET;
      ext   <= INSTR_RESET;
    end else begin
      if (wr_instr) instr <= ins_next;
      if (wr_ext) ext <= ext_next;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flags <= FLAGS_RESET;
    end else if (wr_flags) begin
      flags <= wb_dat_i[7:0];
    end else if (state == S_MEM && mem_done && ccr_pop) begin
      flags <= mem_rdata[15:8];                                                   // [RULE13]
    end else if (fl_move) begin
      flags[FLAG_N] <= fl_neg;                                                    // [RULE10]
      flags[FLAG_Z] <= fl_zero;
      flags[FLAG_V] <= 1'b0;
    end
  end

  // free-running slow peripheral clock
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      e_cnt   <= 8'h00;
      e_clock <= 1'b0;
    end else begin
      e_cnt   <= (e_cnt == E_LAST) ? 8'h00 : 8'(e_cnt + 8'h01);
      e_clock <= (e_cnt >= E_HALF);
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      illegal <= 1'b0;
      taken   <= 1'b0;
    end else if (go) begin
      illegal <= ~legal;
      taken   <= (kind == K_BRANCH) & cc_true(instr[3:0], flags);                   // [RULE9]
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state     <= S_IDLE;
      result    <= 16'h0000;
      ptr       <= 16'h0000;
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_word  <= 1'b0;
      mem_sync  <= 1'b0;
      mem_addr  <= 16'h0000;
      mem_wdata <= 16'h0000;
    end else begin
      unique case (state)
        S_IDLE: if (go && legal && kind != K_BRANCH) state <= S_READ;
        S_READ: state <= S_ADDR;
        S_ADDR: begin
          result <= mv_data;
          ptr    <= ptr_next;
          if (reg_only) begin
            state <= S_WB;                                                       // [RULE3]
          end else begin
            mem_addr  <= ea;
            mem_we    <= ~load_op;
            mem_word  <= word_op;
            mem_wdata <= st_data;
            mem_sync  <= (kind == K_SYNC);                                        // [RULE7] [RULE8]
            mem_req   <= (kind != K_SYNC);
            state     <= (kind == K_SYNC) ? S_EWAIT : S_MEM;
          end
        end
        S_EWAIT: if (e_cnt == E_LAST) begin
          mem_req <= 1'b1;
          state   <= S_MEM;
        end
        S_MEM: if (mem_done) begin
          mem_req  <= 1'b0;
          mem_sync <= 1'b0;
          result   <= ld_data;
          state    <= (load_op && !ccr_pop) ? S_WB : ptr_k ? S_PTR : S_IDLE;
        end
        S_WB: state <= ptr_k ? S_PTR : S_IDLE;                                     // [RULE2]
        S_PTR: state <= S_IDLE;
      endcase
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_push_addr; state == S_ADDR && kind == K_STACK && is_store; endsequence
  sequence s_pop_addr; state == S_ADDR && kind == K_STACK && !is_store; endsequence
  // the pointer itself may end up odd, the word access address never does
  a_push_predec: assert property (s_push_addr |=> mem_req && mem_we && // [RULE1]
                                  mem_addr == (16'($past(ra_data) - 16'h0002) & 16'hfffe) ##[1:30] state == S_PTR)
    else $error("push did not predecrement the stack pointer");
  a_pop_postinc: assert property (s_pop_addr |=> !mem_we && ptr == 16'($past(ra_data) + 16'h0002)) // [RULE2]
    else $error("pop did not postincrement the stack pointer");
  a_imm_move: assert property (state == S_WB && kind == K_IMM16 |-> wr_hi && wr_lo && wr_data == ext) // [RULE3]
    else $error("immediate word move wrote the wrong value");
  a_word_even: assert property (mem_req && mem_word |-> !mem_addr[0]) // [RULE12]
    else $error("word access at odd address");
  a_short_byte: assert property (state == S_ADDR && short_fmt && kind != K_IMM8 |=> // [RULE5]
                                 !mem_word && mem_addr[15:8] == SHORT_PAGE)
    else $error("short absolute access not a byte in the top page");
  a_disp_ext: assert property (state == S_ADDR && kind == K_DISP |=> // [RULE11]
                               mem_addr[15:1] == 15'(($past(ra_data) + ext) >> 1))
    else $error("displacement not taken from the second word");
  a_sync_frame: assert property ($rose(mem_req) && mem_sync |-> e_cnt == 8'h00) // [RULE7] [RULE8]
    else $error("slow transfer not aligned to the slow clock");
  a_ccr_copies: assert property (mem_req && mem_we && kind == K_CCR_STACK |-> // [RULE13]
                                 mem_wdata[15:8] == mem_wdata[7:0])
    else $error("flag push halves differ");
  a_flag_zero: assert property (state == S_WB |=> // [RULE10]
                                flags[FLAG_Z] == ($past(word_op) ? ($past(result) == 16'h0000)
                                : ($past(result[7:0]) == 8'h00)) && !flags[FLAG_V])
    else $error("move flags wrong");
  a_branch_always: assert property (go && kind == K_BRANCH && instr[3:0] == CC_T |=> taken && state == S_IDLE) // [RULE9]
    else $error("always-true branch not taken");
endmodule : cpu_data_transfer_decode

// ---- verif/mem_model.sv ----
`timescale 1ns/1ns
module mem_model (
  // clock and pacing
  input  wire logic        clock,
  input  wire logic [1:0]  stall,
  // memory bus
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic        mem_word,
  input  wire logic        mem_sync,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic      [15:0] mem_rdata,
  output logic             mem_ack
);
  logic [7:0] mem [0:65535];
  logic [1:0] cnt;
  logic       done;
  initial begin
    mem_rdata = 16'h0000;
    mem_ack   = 1'b0;
    cnt       = 2'h0;
    done      = 1'b0;
    for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
  end
  // no address folding here, so a word sent to an odd address lands visibly wrong
  always @(posedge clock) begin
    mem_ack <= 1'b0;
    if (!mem_req) begin
      cnt       <= 2'h0;
      done      <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (!done && (cnt >= stall || mem_sync)) begin
      done    <= 1'b1;
      mem_ack <= !mem_sync;
      if (mem_we && mem_word) {mem[mem_addr], mem[mem_addr + 16'h1]} <= mem_wdata;
      else if (mem_we) mem[mem_addr] <= mem_wdata[7:0];
      else if (mem_word) mem_rdata <= {mem[mem_addr], mem[mem_addr + 16'h1]};
      else mem_rdata <= {~mem[mem_addr], mem[mem_addr]};
    end else if (!done) begin
      cnt <= cnt + 2'h1;
    end
  end
endmodule : mem_model

// ---- verif/testbench.sv ----
`timescale 1ns/1ns
module testbench;
  import xfer_pkg::*;
  localparam int EDIV = 4;
  logic        clock, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, e_clock;
  logic        mem_req, mem_we, mem_word, mem_sync, mem_ack;
  logic [7:0]  wb_adr_i, fl;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rnd, rd;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, v;
  logic [15:0] gpr [0:7];
  logic [1:0]  stall;
  logic [32:0] expq [$];
  logic [32:0] e;
  int          n_mismatch, checks, n_sync;
  int          e_gap = -1;
  logic        e_prev;

  cpu_data_transfer_decode #(.E_DIV(EDIV)) uut (.clock(clock), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_req(mem_req), .mem_we(mem_we), .mem_word(mem_word),
    .mem_sync(mem_sync), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .e_clock(e_clock));
  mem_model mm (.clock(clock), .stall(stall), .mem_req(mem_req), .mem_we(mem_we), .mem_word(mem_word),
    .mem_sync(mem_sync), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  always #25 clock = ~clock;

  task automatic give_verdict;
    $display("counts: checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // reads are strictly sequential, so notes come back in issue order
  always @(posedge clock) begin
    if (mem_req === 1'b1 && mem_sync === 1'b1) n_sync++;
    // the slow clock must keep a steady period of EDIV system clocks
    if (e_clock === 1'b1 && e_prev === 1'b0) begin
      if (e_gap >= 0) cmp(32'(e_gap), EDIV);
      e_gap = 0;
    end
    if (e_gap >= 0) e_gap++;
    e_prev = e_clock;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expq.size() > 0) begin
      e = expq.pop_front();
      if (e[32]) cmp(wb_dat_o, e[31:0]);
    end
  end

  function automatic logic [15:0] nxt();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd[15:0];
  endfunction : nxt

  function automatic logic [15:0] enc(input logic [3:0] k, input logic s, input logic d, input logic [2:0] m,
                                      input logic [3:0] n);
    return {k, s, d, 3'h0, m, n};
  endfunction : enc

  function automatic logic cond(input logic [3:0] cc, input logic [3:0] f);
    logic r;
    case (cc[3:1])
      3'h0: r = 1'b1;
      3'h1: r = !(f[FLAG_C] | f[FLAG_Z]);
      3'h2: r = !f[FLAG_C];
      3'h3: r = !f[FLAG_Z];
      3'h4: r = !f[FLAG_V];
      3'h5: r = !f[FLAG_N];
      3'h6: r = !(f[FLAG_N] ^ f[FLAG_V]);
      default: r = !(f[FLAG_Z] | (f[FLAG_N] ^ f[FLAG_V]));
    endcase
    return r ^ cc[0];
  endfunction : cond

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'h3;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) begin
      n_mismatch++;
      give_verdict();
    end
  endtask : wb

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb(1'b1, adr, dat);
  endtask : wr

  task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
    expq.push_back({1'b1, exp});
    wb(1'b0, adr, 32'h0);
  endtask : rdc

  task automatic run(input logic [15:0] ins, input logic [15:0] ext);
    int n;
    logic [15:0] s;
    s = nxt();
    stall <= s[1:0];
    wr(OFS_EXT, {16'h0, ext});
    wr(OFS_INSTR, {16'h0, ins});
    wr(OFS_CTRL, 32'h1);
    n = 0;
    do begin
      expq.push_back(33'h0);
      wb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rd[ST_BUSY] !== 1'b0 && n < 100);
    if (n >= 100) begin
      n_mismatch++;
      give_verdict();
    end
  endtask : run

  // moves set N and Z from the moved value, clear V and keep C
  task automatic mvchk(input int r, input logic [15:0] x, input logic w);
    fl = {fl[7:4], w ? x[15] : x[7], w ? x == 16'h0 : x[7:0] == 8'h0, 1'b0, fl[FLAG_C]};
    rdc(8'h20 + {3'h0, 3'(r), 2'b00}, {16'h0, gpr[r]});
    rdc(OFS_FLAGS, {24'h0, fl});
  endtask : mvchk

  task automatic memb(input logic [15:0] a, input logic [7:0] x);
    cmp({24'h0, mm.mem[a]}, {24'h0, x});
  endtask : memb

  task automatic memw(input logic [15:0] a, input logic [15:0] x);
    memb(a, x[15:8]);
    memb(a + 16'h1, x[7:0]);
  endtask : memw

  initial begin
    clock    = 1'b0;
    arst_n   = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    stall    = 2'h0;
    rnd      = 32'd90;
    fl       = 8'h00;
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    rdc(OFS_FLAGS, 32'h0);
    rdc(8'h80, 32'h0);
    for (int r = 0; r < 8; r++) begin
      gpr[r] = nxt();
      run(enc(K_IMM16, 1'b1, 1'b0, 3'h0, 4'(r)), gpr[r]);
      mvchk(r, gpr[r], 1'b1);
    end
    v = nxt();
    run({K_IMM8, 4'ha, v[7:0]}, 16'h0);
    gpr[2][7:0] = v[7:0];
    mvchk(2, v, 1'b0);
    run({K_IMM8, 4'h3, 8'h00}, 16'h0);
    gpr[3][15:8] = 8'h00;
    mvchk(3, 16'h0, 1'b0);
    $display("test immediate done");
    gpr[4] = 16'h1000;
    run(enc(K_IMM16, 1'b1, 1'b0, 3'h0, 4'h4), 16'h1000);
    run(enc(K_IND, 1'b1, 1'b1, 3'h4, 4'h1), 16'h0);
    memw(16'h1000, gpr[1]);
    run(enc(K_DISP, 1'b1, 1'b1, 3'h4, 4'h2), 16'h0011);
    memw(16'h1010, gpr[2]);
    run(enc(K_ABS16, 1'b1, 1'b0, 3'h0, 4'h5), 16'h1011);
    gpr[5] = gpr[2];
    mvchk(5, gpr[5], 1'b1);
    run(enc(K_AUTO, 1'b1, 1'b1, 3'h4, 4'h1), 16'h0);
    memw(16'h0ffe, gpr[1]);
    run(enc(K_AUTO, 1'b1, 1'b0, 3'h4, 4'h6), 16'h0);
    gpr[6] = gpr[1];
    mvchk(6, gpr[6], 1'b1);
    mvchk(4, gpr[6], 1'b1);
    run(enc(K_DISP, 1'b0, 1'b1, 3'h4, 4'h9), 16'h0003);
    memb(16'h1003, gpr[1][7:0]);
    run(enc(K_ABS16, 1'b0, 1'b0, 3'h0, 4'h0), 16'h1003);
    gpr[0][15:8] = gpr[1][7:0];
    mvchk(0, gpr[1], 1'b0);
    run(enc(K_RR, 1'b1, 1'b0, 3'h3, 4'h7), 16'h0);
    gpr[7] = gpr[3];
    mvchk(7, gpr[7], 1'b1);
    run({K_ABS8_ST, 4'h9, 8'h10}, 16'h0);
    memb(16'hff10, gpr[1][7:0]);
    run({K_ABS8_LD, 4'h6, 8'h10}, 16'h0);
    gpr[6][15:8] = gpr[1][7:0];
    mvchk(6, gpr[1], 1'b0);
    $display("test memory moves done");
    n_sync = 0;
    run(enc(K_SYNC, 1'b0, 1'b1, 3'h0, 4'h9), 16'h2005);
    memb(16'h2005, gpr[1][7:0]);
    mm.mem[16'h2006] = 8'h5a;
    run(enc(K_SYNC, 1'b0, 1'b0, 3'h0, 4'hb), 16'h2006);
    gpr[3][7:0] = 8'h5a;
    mvchk(3, 16'h005a, 1'b0);
    cmp(32'(n_sync >= 2 && n_sync <= 2 * EDIV + 2), 32'h1);
    $display("test slow sync done");
    // stack traffic stays word sized
    gpr[7] = 16'h0101;
    run(enc(K_IMM16, 1'b1, 1'b0, 3'h0, 4'h7), 16'h0101);
    run(enc(K_STACK, 1'b1, 1'b1, 3'h0, 4'h1), 16'h0);
    memw(16'h00fe, gpr[1]);
    rdc(8'h3c, 32'h00ff);
    run(enc(K_STACK, 1'b1, 1'b0, 3'h0, 4'h2), 16'h0);
    gpr[2] = gpr[1];
    mvchk(2, gpr[2], 1'b1);
    rdc(8'h3c, 32'h0101);
    v = nxt();
    wr(OFS_FLAGS, {28'h0, v[3:0]});
    run(enc(K_CCR_STACK, 1'b1, 1'b1, 3'h0, 4'h0), 16'h0);
    memw(16'h00fe, {2{4'h0, v[3:0]}});
    mm.mem[16'h00ff] = 8'h0a;
    mm.mem[16'h00fe] = 8'h05;
    run(enc(K_CCR_STACK, 1'b1, 1'b0, 3'h0, 4'h0), 16'h0);
    rdc(OFS_FLAGS, 32'h5);
    rdc(8'h3c, 32'h0101);
    $display("test stack done");
    for (int i = 0; i < 32; i++) begin
      v = nxt();
      wr(OFS_FLAGS, {28'h0, v[3:0]});
      run({K_BRANCH, 8'h00, 4'(i)}, 16'h0);
      rdc(OFS_STATUS, {29'h0, cond(4'(i), v[3:0]), 2'b00});
    end
    run(16'hd000, 16'h0);
    rdc(OFS_STATUS, 32'h2);
    $display("test branch done");
    give_verdict();
  end
endmodule : testbench
